// ==== design/job_aux_pkg.sv ====
// Package: constants and types for the job-control auxiliary I/O block
package job_aux_pkg;

    // ------------------------------------------------------------
    // Widths and counts
    // ------------------------------------------------------------
    localparam int WAIT_LINES     = 4;
    localparam int GEN_OUTS       = 4;
    localparam int ENC_CHANNELS   = 2;
    localparam int ENC_POS_W      = 32;
    localparam int SYNC_STAGES    = 2;
    localparam int WAIT_SEL_W     = 3;

    // ------------------------------------------------------------
    // Wait source codes (index 0..3 are wait inputs)
    // ------------------------------------------------------------
    localparam logic [WAIT_SEL_W-1:0] WAIT_SEL_START = 3'h4;

    // ------------------------------------------------------------
    // Register bus map (all offsets chosen for this block)
    // ------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] REG_CTRL      = 4'h0;
    localparam logic [ADDR_W-1:0] REG_STATUS    = 4'h1;
    localparam logic [ADDR_W-1:0] REG_IRQ_STAT  = 4'h2;
    localparam logic [ADDR_W-1:0] REG_IRQ_MASK  = 4'h3;
    localparam logic [ADDR_W-1:0] REG_ENC0_POS  = 4'h4;
    localparam logic [ADDR_W-1:0] REG_ENC1_POS  = 4'h5;
    localparam logic [ADDR_W-1:0] REG_INPUTS    = 4'h6;

    // CTRL write bits
    localparam int CTRL_READY_BIT  = 0;
    localparam int CTRL_FAULT_BIT  = 1;

    // Interrupt status bits
    localparam int IRQ_W           = 4;
    localparam int IRQ_ABORT_BIT   = 0;
    localparam int IRQ_EXTRST_BIT  = 1;
    localparam int IRQ_WAITDONE_BIT = 2;
    localparam int IRQ_JOBEND_BIT  = 3;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;

    // ------------------------------------------------------------
    // Job execution states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        JOB_IDLE,
        JOB_RUN,
        JOB_WAIT
    } job_state_t;

endpackage

// ==== design/quad_decoder.sv ====
// Quadrature decoder with input synchronisers for one encoder channel
`timescale 1ns/1ps
`default_nettype none
module quad_decoder
    import job_aux_pkg::*;
#(
    parameter int POS_W = ENC_POS_W
) (
    // Clock and reset
    input  wire logic             core_clk_in,
    input  wire logic             rst_n_in,
    // Phases, single-ended level
    input  wire logic             phase_a_in,
    input  wire logic             phase_b_in,
    // Position
    output logic [POS_W-1:0]      position_out
);

    logic [1:0]       meta_ff;
    logic [1:0]       nxt_meta;
    logic [1:0]       sync_ff;
    logic [1:0]       nxt_sync;
    logic [1:0]       prev_ff;
    logic [1:0]       nxt_prev;
    logic [POS_W-1:0] pos_ff;
    logic [POS_W-1:0] nxt_pos;

    // ------------------------------------------------------------
    // two-stage synchroniser
    // ------------------------------------------------------------
    // direction from leading phase
    always_comb begin
        nxt_meta = {phase_a_in, phase_b_in};
        nxt_sync = meta_ff;
        nxt_prev = sync_ff;
        nxt_pos  = pos_ff;
        // Gray step: A leading B counts up; double steps ignored
        case ({prev_ff, sync_ff})
            4'h2, 4'hB, 4'hD, 4'h4: nxt_pos = pos_ff + POS_W'(1);
            4'h1, 4'h7, 4'hE, 4'h8: nxt_pos = pos_ff - POS_W'(1);
            default:                nxt_pos = pos_ff;
        endcase
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            meta_ff <= 2'h0;
            sync_ff <= 2'h0;
            prev_ff <= 2'h0;
            pos_ff  <= '0;
        end else begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
            prev_ff <= nxt_prev;
            pos_ff  <= nxt_pos;
        end
    end

    assign position_out = pos_ff;

endmodule
`default_nettype wire

// ==== design/job_control_aux_io.sv ====
// Job-control auxiliary I/O: job state, status outputs, wait inputs, encoders
// Functional notes
// - Abort input ends job, returns idle
// - Wait on chosen input until asserted
// - Fault/ready low once system ready
// - Fault/ready high at reset, on fault
// - Job-active high whenever job exists
// - Busy set by open, cleared by close
// - Marking output from marking start until end
// - General outputs follow set-outputs instruction
// - Primary encoder takes A/B phases
// - Secondary encoder independent A/B phases
// - External reset low forces soft reset
// - Job may also wait on start
`timescale 1ns/1ps
`default_nettype none
module job_control_aux_io
    import job_aux_pkg::*;
(
    // Clock and reset
    input  wire logic                  core_clk_in,
    input  wire logic                  rst_n_in,
    // Isolated external inputs
    input  wire logic                  abort_in,
    input  wire logic                  ext_reset_n_in,
    input  wire logic                  start_in,
    input  wire logic [WAIT_LINES-1:0] wait_input_in,
    // Encoder phases, receiver outputs (single-ended level)
    input  wire logic                  enc0_phase_a_in,
    input  wire logic                  enc0_phase_b_in,
    input  wire logic                  enc1_phase_a_in,
    input  wire logic                  enc1_phase_b_in,
    // Job sequencer instructions (one-cycle pulses)
    input  wire logic                  job_open_instr_in,
    input  wire logic                  job_close_instr_in,
    input  wire logic                  mark_begin_in,
    input  wire logic                  wait_instr_in,
    input  wire logic [WAIT_SEL_W-1:0] wait_sel_in,
    input  wire logic                  set_outputs_instr_in,
    input  wire logic [GEN_OUTS-1:0]   set_outputs_val_in,
    input  wire logic                  set_outputs_beam_on_in,
    input  wire logic                  beam_off_cmd_in,
    // Register bus
    input  wire logic [ADDR_W-1:0]     reg_addr_in,
    input  wire logic [31:0]           reg_wdata_in,
    input  wire logic                  reg_wr_in,
    input  wire logic                  reg_rd_in,
    output logic [31:0]                reg_rdata_out,
    // Status outputs
    output logic                       fault_ready_out,
    output logic                       job_active_out,
    output logic                       busy_out,
    output logic                       beam_marking_out,
    output logic [GEN_OUTS-1:0]        general_out,
    output logic                       job_paused_out,
    output logic                       soft_reset_out,
    output logic                       irq_out
);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    localparam int NSYNC = WAIT_LINES + 3;
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] meta_ff;
    logic [NSYNC-1:0] sync_ff;
    logic [NSYNC-1:0] nxt_meta;
    logic [NSYNC-1:0] nxt_sync;
    logic             abort_s;
    logic             ext_rst_s;
    logic             start_s;
    logic [WAIT_LINES-1:0] wait_s;

    assign raw_in = {start_in, ext_reset_n_in, abort_in, wait_input_in};

    always_comb begin
        nxt_meta = raw_in;
        nxt_sync = meta_ff;
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            meta_ff <= {1'b0, 1'b1, 1'b0, {WAIT_LINES{1'b0}}};
            sync_ff <= {1'b0, 1'b1, 1'b0, {WAIT_LINES{1'b0}}};
        end else begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
        end
    end

    assign wait_s    = sync_ff[WAIT_LINES-1:0];
    assign abort_s   = sync_ff[WAIT_LINES];
    assign ext_rst_s = ~sync_ff[WAIT_LINES+1];
    assign start_s   = sync_ff[WAIT_LINES+2];

    // ------------------------------------------------------------
    // Job state machine
    // ------------------------------------------------------------
    job_state_t            state_ff;
    job_state_t            nxt_state;
    logic [WAIT_SEL_W-1:0] wsel_ff;
    logic [WAIT_SEL_W-1:0] nxt_wsel;
    logic                  busy_ff;
    logic                  nxt_busy;
    logic                  active_ff;
    logic                  nxt_active;
    logic                  mark_ff;
    logic                  nxt_mark;
    logic [GEN_OUTS-1:0]   gpo_ff;
    logic [GEN_OUTS-1:0]   nxt_gpo;
    logic                  paused_ff;
    logic                  nxt_paused;
    logic                  wait_met;
    logic                  wait_done;
    logic                  job_end;
    logic                  abort_evt;

    always_comb begin
        if (wsel_ff == WAIT_SEL_START) begin
            wait_met = start_s;
        end else if (wsel_ff < WAIT_SEL_START) begin
            wait_met = wait_s[wsel_ff[1:0]];
        end else begin
            wait_met = 1'b1;
        end
    end

    assign abort_evt = abort_s && (state_ff != JOB_IDLE);
    assign wait_done = (state_ff == JOB_WAIT) && wait_met && !abort_s;
    assign job_end   = (state_ff != JOB_IDLE) && job_close_instr_in && !abort_s;

    always_comb begin
        nxt_state  = state_ff;
        nxt_wsel   = wsel_ff;
        nxt_busy   = busy_ff;
        nxt_mark   = mark_ff;
        nxt_gpo    = gpo_ff;
        case (state_ff)
            JOB_IDLE: begin
                if (job_open_instr_in && !abort_s) begin
                    nxt_state = JOB_RUN;
                end
            end
            JOB_RUN: begin
                if (wait_instr_in) begin
                    nxt_state = JOB_WAIT;
                    nxt_wsel  = wait_sel_in;
                end
            end
            JOB_WAIT: begin
                if (wait_met) begin
                    nxt_state = JOB_RUN;
                end
            end
            default: begin
                nxt_state = JOB_IDLE;
            end
        endcase
        if (job_open_instr_in) begin
            nxt_busy = 1'b1;
        end
        if (job_close_instr_in) begin
            nxt_busy = 1'b0;
            nxt_state = JOB_IDLE;
        end
        if (mark_begin_in && state_ff != JOB_IDLE) begin
            nxt_mark = 1'b1;
        end
        if (beam_off_cmd_in || (set_outputs_instr_in && !set_outputs_beam_on_in)) begin
            nxt_mark = 1'b0;
        end
        if (set_outputs_instr_in) begin
            nxt_gpo = set_outputs_val_in;
        end
        if (job_close_instr_in) begin
            nxt_mark = 1'b0;
        end
        if (abort_s) begin
            nxt_state = JOB_IDLE;
            nxt_busy  = 1'b0;
            nxt_mark  = 1'b0;
        end
        nxt_active = (nxt_state != JOB_IDLE);
        nxt_paused = (nxt_state == JOB_WAIT);
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            state_ff  <= JOB_IDLE;
            wsel_ff   <= '0;
            busy_ff   <= 1'b0;
            active_ff <= 1'b0;
            mark_ff   <= 1'b0;
            gpo_ff    <= '0;
            paused_ff <= 1'b0;
        end else begin
            state_ff  <= nxt_state;
            wsel_ff   <= nxt_wsel;
            busy_ff   <= nxt_busy;
            active_ff <= nxt_active;
            mark_ff   <= nxt_mark;
            gpo_ff    <= nxt_gpo;
            paused_ff <= nxt_paused;
        end
    end

    // ------------------------------------------------------------
    // Encoders
    // ------------------------------------------------------------
    logic [ENC_POS_W-1:0] enc_pos [ENC_CHANNELS];
    logic [ENC_CHANNELS-1:0] enc_a;
    logic [ENC_CHANNELS-1:0] enc_b;
    assign enc_a = {enc1_phase_a_in, enc0_phase_a_in};
    assign enc_b = {enc1_phase_b_in, enc0_phase_b_in};

    for (genvar g = 0; g < ENC_CHANNELS; g++) begin : g_enc
        quad_decoder #(
            .POS_W        (ENC_POS_W)
        ) u_dec (
            .core_clk_in  (core_clk_in),
            .rst_n_in     (rst_n_in),
            .phase_a_in   (enc_a[g]),
            .phase_b_in   (enc_b[g]),
            .position_out (enc_pos[g])
        );
    end

    // ------------------------------------------------------------
    // Registers, ready/fault, interrupts
    // ------------------------------------------------------------
    logic              ready_ff;
    logic              nxt_ready;
    logic              fault_ff;
    logic              nxt_fault;
    logic              fr_ff;
    logic              nxt_fr;
    logic              srst_ff;
    logic              nxt_srst;
    logic [IRQ_W-1:0]  ist_ff;
    logic [IRQ_W-1:0]  nxt_ist;
    logic [IRQ_W-1:0]  imask_ff;
    logic [IRQ_W-1:0]  nxt_imask;
    logic [IRQ_W-1:0]  ev;
    logic              irq_ff;
    logic              nxt_irq;
    logic [31:0]       rdata_ff;
    logic [31:0]       nxt_rdata;
    logic              wr_ctrl;

    assign wr_ctrl = reg_wr_in && (reg_addr_in == REG_CTRL);

    always_comb begin
        ev = '0;
        ev[IRQ_ABORT_BIT]    = abort_evt;
        ev[IRQ_EXTRST_BIT]   = ext_rst_s;
        ev[IRQ_WAITDONE_BIT] = wait_done;
        ev[IRQ_JOBEND_BIT]   = job_end;
        nxt_ready = ready_ff;
        nxt_fault = fault_ff;
        // Ready is firmware's word; cleared again by soft reset
        if (wr_ctrl) begin
            nxt_ready = reg_wdata_in[CTRL_READY_BIT];
            nxt_fault = fault_ff | reg_wdata_in[CTRL_FAULT_BIT];
        end
        if (ext_rst_s) begin
            nxt_ready = 1'b0;
            nxt_fault = 1'b0;
        end
        // low only when ready, no fault
        // high at power-up or on fault
        nxt_fr   = !(nxt_ready && !nxt_fault);
        nxt_srst = ext_rst_s;
        // Set beats write-one-clear
        nxt_ist = ist_ff;
        if (reg_wr_in && reg_addr_in == REG_IRQ_STAT) begin
            nxt_ist = ist_ff & ~reg_wdata_in[IRQ_W-1:0];
        end
        nxt_ist = nxt_ist | ev;
        nxt_imask = imask_ff;
        if (reg_wr_in && reg_addr_in == REG_IRQ_MASK) begin
            nxt_imask = reg_wdata_in[IRQ_W-1:0];
        end
        nxt_irq = |(nxt_ist & nxt_imask);
        nxt_rdata = 32'h0;
        if (reg_rd_in) begin
            case (reg_addr_in)
                REG_CTRL:     nxt_rdata = {30'h0, fault_ff, ready_ff};
                REG_STATUS:   nxt_rdata = {20'h0, gpo_ff, paused_ff, fr_ff, mark_ff, busy_ff,
                                           active_ff, 1'b0, state_ff};
                REG_IRQ_STAT: nxt_rdata = {28'h0, ist_ff};
                REG_IRQ_MASK: nxt_rdata = {28'h0, imask_ff};
                REG_ENC0_POS: nxt_rdata = enc_pos[0];
                REG_ENC1_POS: nxt_rdata = enc_pos[1];
                REG_INPUTS:   nxt_rdata = {25'h0, sync_ff};
                default:      nxt_rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            ready_ff <= 1'b0;
            fault_ff <= 1'b0;
            fr_ff    <= 1'b1;
            srst_ff  <= 1'b0;
            ist_ff   <= '0;
            imask_ff <= IRQ_MASK_RST;
            irq_ff   <= 1'b0;
            rdata_ff <= 32'h0;
        end else begin
            ready_ff <= nxt_ready;
            fault_ff <= nxt_fault;
            fr_ff    <= nxt_fr;
            srst_ff  <= nxt_srst;
            ist_ff   <= nxt_ist;
            imask_ff <= nxt_imask;
            irq_ff   <= nxt_irq;
            rdata_ff <= nxt_rdata;
        end
    end

    assign fault_ready_out  = fr_ff;
    assign job_active_out   = active_ff;
    assign busy_out         = busy_ff;
    assign beam_marking_out = mark_ff;
    assign general_out      = gpo_ff;
    assign job_paused_out   = paused_ff;
    assign soft_reset_out   = srst_ff;
    assign irq_out          = irq_ff;
    assign reg_rdata_out    = rdata_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_abort_idle: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        abort_s |=> (state_ff == JOB_IDLE) && !mark_ff && !busy_ff)
        else $error("abort did not return job to idle");
    chk_wait_hold: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (state_ff == JOB_WAIT && !wait_met && !abort_s && !job_close_instr_in) |=> state_ff == JOB_WAIT)
        else $error("wait released without its input");
    chk_wait_release: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (state_ff == JOB_WAIT && wait_met && !abort_s && !job_close_instr_in) |=> state_ff == JOB_RUN)
        else $error("wait not released by its input");
    chk_ready_low: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        !fr_ff |-> ready_ff && !fault_ff)
        else $error("fault/ready low while not ready");
    chk_fault_high: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (wr_ctrl && reg_wdata_in[CTRL_FAULT_BIT] && !ext_rst_s) |=> fr_ff)
        else $error("fault did not raise fault/ready");
    chk_active_job: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        ##1 active_ff == (state_ff != JOB_IDLE))
        else $error("job-active disagrees with job state");
    chk_busy_open: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (job_open_instr_in && !job_close_instr_in && !abort_s) |=> busy_ff)
        else $error("busy not set by job open");
    chk_mark_clear: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        beam_off_cmd_in |=> !mark_ff)
        else $error("beam-off did not clear marking");
    chk_gpo_set: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        set_outputs_instr_in |=> gpo_ff == $past(set_outputs_val_in))
        else $error("general outputs not set");
    chk_srst_follow: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        $fell(sync_ff[WAIT_LINES+1]) |=> soft_reset_out ##0 !ready_ff)
        else $error("external reset did not soft reset");

endmodule
`default_nettype wire

// ==== tb/quad_encoder_model.sv ====
// Quadrature encoder model driving the A/B phases of one channel
`timescale 1ns/1ps
`default_nettype none
module quad_encoder_model (
    // Clock
    input  wire logic clk_in,
    // Step request
    input  wire logic step_in,
    input  wire logic fwd_in,
    // Phases
    output logic      phase_a_out,
    output logic      phase_b_out
);
    logic [1:0] ph_ff = 2'h0;
    // ----------------
    // Phase sequence
    // ----------------
    // A leads forward
    always @(posedge clk_in) begin
        if (step_in) begin
            ph_ff <= fwd_in ? ph_ff + 2'h1 : ph_ff - 2'h1;
        end
    end
    // Gray order, so one phase moves per step
    assign phase_a_out = (ph_ff == 2'h1) || (ph_ff == 2'h2);
    assign phase_b_out = ph_ff[1];
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking testbench for the job-control auxiliary I/O block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import job_aux_pkg::*;
    logic        core_clk_in = 1'b0;
    logic        rst_n_in = 1'b0;
    logic        abort_in = 1'b0;
    logic        ext_reset_n_in = 1'b1;
    logic        start_in = 1'b0;
    logic [3:0]  wait_input_in = 4'h0;
    wire logic [1:0] enc_a;
    wire logic [1:0] enc_b;
    logic [1:0]  step = 2'h0;
    logic [1:0]  fwd = 2'h0;
    logic        open_i = 1'b0, close_i = 1'b0, mark_i = 1'b0, wait_i = 1'b0;
    logic        set_i = 1'b0, beam_on = 1'b0, boff_i = 1'b0;
    logic [2:0]  wsel = 3'h0;
    logic [3:0]  set_val = 4'h0;
    logic [3:0]  addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0, rd = 1'b0;
    logic [31:0] rdata, r;
    logic        fr, act, busy, mark, paused, srst, irq;
    logic [3:0]  gpo;
    logic        e_busy = 1'b0, e_mark = 1'b0;
    logic [3:0]  e_gpo = 4'h0;
    int          n_fail = 0;
    int          checked = 0;
    int          pos [2] = '{0, 0};

    always #2.5 core_clk_in = ~core_clk_in;

    job_control_aux_io dut_u (
        .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .abort_in(abort_in),
        .ext_reset_n_in(ext_reset_n_in), .start_in(start_in), .wait_input_in(wait_input_in),
        .enc0_phase_a_in(enc_a[0]), .enc0_phase_b_in(enc_b[0]),
        .enc1_phase_a_in(enc_a[1]), .enc1_phase_b_in(enc_b[1]),
        .job_open_instr_in(open_i), .job_close_instr_in(close_i), .mark_begin_in(mark_i),
        .wait_instr_in(wait_i), .wait_sel_in(wsel), .set_outputs_instr_in(set_i),
        .set_outputs_val_in(set_val), .set_outputs_beam_on_in(beam_on), .beam_off_cmd_in(boff_i),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_rdata_out(rdata), .fault_ready_out(fr), .job_active_out(act), .busy_out(busy),
        .beam_marking_out(mark), .general_out(gpo), .job_paused_out(paused),
        .soft_reset_out(srst), .irq_out(irq)
    );
    quad_encoder_model enc0_u (.clk_in(core_clk_in), .step_in(step[0]), .fwd_in(fwd[0]),
        .phase_a_out(enc_a[0]), .phase_b_out(enc_b[0]));
    quad_encoder_model enc1_u (.clk_in(core_clk_in), .step_in(step[1]), .fwd_in(fwd[1]),
        .phase_a_out(enc_a[1]), .phase_b_out(enc_b[1]));

    // ----------------
    // Helpers
    // ----------------
    task automatic test_done();
        $display("Counts: checked %0d, failed %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic go();
        @(posedge core_clk_in);
        {open_i, close_i, mark_i, wait_i, set_i, boff_i, wr, rd} <= 8'h00;
        #1;
    endtask
    task automatic tick();
        @(posedge core_clk_in);
        #1;
    endtask
    // Instruction pulse, with the bench model following it
    task automatic pulse(input int k, input logic [4:0] v);
        @(posedge core_clk_in);
        case (k)
            0: begin open_i <= 1'b1; e_busy = 1'b1; end
            1: begin close_i <= 1'b1; e_busy = 1'b0; e_mark = 1'b0; end
            2: begin mark_i <= 1'b1; e_mark = e_mark | e_busy; end
            3: begin wait_i <= 1'b1; wsel <= v[2:0]; end
            4: begin set_i <= 1'b1; set_val <= v[3:0]; beam_on <= v[4];
                e_gpo = v[3:0]; e_mark = e_mark & v[4]; end
            default: begin boff_i <= 1'b1; e_mark = 1'b0; end
        endcase
        go();
    endtask
    task automatic cmp();
        chk("busy", 32'(e_busy), 32'(busy));
        chk("active", 32'(e_busy), 32'(act));
        chk("marking", 32'(e_mark), 32'(mark));
        chk("general_out", 32'(e_gpo), 32'(gpo));
    endtask
    task automatic wreg(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        go();
    endtask
    task automatic rreg(input logic [3:0] a, input logic [31:0] e, input string n);
        @(posedge core_clk_in);
        addr <= a;
        rd <= 1'b1;
        go();
        chk(n, e, rdata);
    endtask
    function automatic logic sig(input int w);
        case (w)
            0: return paused;
            1: return act;
            default: return srst;
        endcase
    endfunction
    // Bounded wait: running out is a mismatch and ends the run
    task automatic wait_for(input int w, input logic v);
        for (int i = 0; i < 20; i++) begin
            tick();
            if (sig(w) === v) return;
        end
        n_fail++;
        $display("[ERR] wait %0d expected %b seen %b", w, v, sig(w));
        test_done();
    endtask

    // ----------------
    // Main sequence
    // ----------------
    initial begin
        void'($urandom(32'h9001e5f2));
        repeat (15) @(posedge core_clk_in);
        #1;
        chk("fault_ready reset", 32'h1, 32'(fr));
        cmp();
        @(posedge core_clk_in);
        rst_n_in <= 1'b1;
        wreg(REG_CTRL, 32'h1);
        tick();
        chk("fault_ready ready", 32'h0, 32'(fr));
        wreg(REG_CTRL, 32'h2);
        tick();
        chk("fault_ready fault", 32'h1, 32'(fr));
        @(posedge core_clk_in);
        ext_reset_n_in <= 1'b0;
        wait_for(2, 1'b1);
        @(posedge core_clk_in);
        ext_reset_n_in <= 1'b1;
        wait_for(2, 1'b0);
        wreg(REG_CTRL, 32'h1);
        tick();
        chk("fault_ready after reset", 32'h0, 32'(fr));
        $display("test ready/fault done");

        pulse(2, 5'h00);
        cmp();
        pulse(0, 5'h00);
        cmp();
        pulse(2, 5'h00);
        cmp();
        rreg(REG_STATUS, 32'h39, "status");
        for (int i = 0; i < 4; i++) begin
            pulse(4, {i != 3, 4'($urandom)});
            cmp();
        end
        pulse(2, 5'h00);
        pulse(5, 5'h00);
        cmp();
        pulse(1, 5'h00);
        cmp();
        $display("test job outputs done");

        wreg(REG_IRQ_STAT, 32'hF);
        for (int s = 0; s < 5; s++) begin
            pulse(0, 5'h00);
            pulse(3, 5'(s));
            chk("paused", 32'h1, 32'(paused));
            chk("active paused", 32'h1, 32'(act));
            @(posedge core_clk_in);
            wait_input_in <= (s == 4) ? 4'hF : ~4'(1 << s);
            start_in <= (s != 4);
            repeat (5) @(posedge core_clk_in);
            #1;
            chk("paused other", 32'h1, 32'(paused));
            @(posedge core_clk_in);
            wait_input_in <= 4'(1 << s);
            start_in <= (s == 4);
            wait_for(0, 1'b0);
            @(posedge core_clk_in);
            wait_input_in <= 4'h0;
            start_in <= 1'b0;
            pulse(1, 5'h00);
        end
        pulse(0, 5'h00);
        pulse(3, 5'(5 + $urandom % 3));
        tick();
        chk("paused no wait", 32'h0, 32'(paused));
        pulse(1, 5'h00);
        rreg(REG_IRQ_STAT, 32'hC, "irq status");
        chk("irq masked", 32'h0, 32'(irq));
        $display("test wait inputs done");

        wreg(REG_IRQ_STAT, 32'hF);
        wreg(REG_IRQ_MASK, 32'h1);
        pulse(0, 5'h00);
        pulse(2, 5'h00);
        @(posedge core_clk_in);
        abort_in <= 1'b1;
        wait_for(1, 1'b0);
        tick();
        chk("marking abort", 32'h0, 32'(mark));
        chk("irq abort", 32'h1, 32'(irq));
        @(posedge core_clk_in);
        abort_in <= 1'b0;
        repeat (4) @(posedge core_clk_in);
        wreg(REG_IRQ_STAT, 32'h1);
        tick();
        chk("irq cleared", 32'h0, 32'(irq));
        pulse(1, 5'h00);
        cmp();
        $display("test abort done");

        for (int i = 0; i < 60; i++) begin
            @(posedge core_clk_in);
            r = $urandom;
            step <= r[1:0];
            fwd <= r[3:2];
            for (int c = 0; c < 2; c++) begin
                if (r[c]) pos[c] += r[c + 2] ? 1 : -1;
            end
            @(posedge core_clk_in);
            step <= 2'h0;
            repeat (3) @(posedge core_clk_in);
        end
        repeat (8) @(posedge core_clk_in);
        rreg(REG_ENC0_POS, 32'(pos[0]), "enc0 position");
        rreg(REG_ENC1_POS, 32'(pos[1]), "enc1 position");
        for (int a = 7; a < 16; a++) begin
            rreg(4'(a), 32'h0, "unmapped");
        end
        $display("test encoders and map done");
        test_done();
    end
endmodule
`default_nettype wire
